/* include/wam_pkg.sv */
// Package for the warning and alarm manager: offsets, reset values, limits and carrier types
package wam_pkg;

    // Timing
    localparam int unsigned CLK_FREQ_HZ  = 125_000_000;
    localparam int unsigned SEC_PER_TICK = 1;
    localparam int unsigned SEC_CYCLES   = CLK_FREQ_HZ * SEC_PER_TICK;
    localparam int unsigned FAN_STOP_S   = 1;
    localparam logic [3:0]  HOLD_MAX_S   = 4'ha;

    // Detection thresholds
    localparam logic [7:0]  LOAD_WARN_PCT = 8'h55;
    localparam logic [11:0] BATT_WARN_MV  = 12'hc80;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL        = 8'h00;
    localparam logic [7:0] ADDR_HOLD        = 8'h04;
    localparam logic [7:0] ADDR_MASK        = 8'h08;
    localparam logic [7:0] ADDR_SEL_ONE     = 8'h0c;
    localparam logic [7:0] ADDR_SEL_TWO     = 8'h10;
    localparam logic [7:0] ADDR_ENC_LIMIT   = 8'h14;
    localparam logic [7:0] ADDR_EXT_LIMIT   = 8'h18;
    localparam logic [7:0] ADDR_LIFE_THRESH = 8'h1c;
    localparam logic [7:0] ADDR_WARN_STAT   = 8'h20;
    localparam logic [7:0] ADDR_ALARM_STAT  = 8'h24;
    localparam logic [7:0] ADDR_SNAPSHOT    = 8'h28;

    // Field positions
    localparam int unsigned CTRL_CLEAR_BIT  = 0;
    localparam int unsigned ASTAT_ACT_BIT   = 0;
    localparam int unsigned ASTAT_PCYC_BIT  = 1;
    localparam int unsigned ASTAT_IMM_BIT   = 2;
    localparam int unsigned ASTAT_CODE_LSB  = 8;

    // Reset values
    localparam logic [3:0]  HOLD_RST        = 4'h1;
    localparam logic [10:0] MASK_RST        = 11'h000;
    localparam logic [3:0]  SEL_RST         = 4'h0;
    localparam logic [7:0]  ENC_LIMIT_RST   = 8'h03;
    localparam logic [15:0] LIFE_THRESH_RST = 16'h0064;

    // Warning table, index n is warning An
    localparam int unsigned NUM_WARN = 10;
    localparam logic [9:0][3:0] WARN_MASK_BIT =
        {4'ha, 4'h8, 4'h2, 4'h9, 4'h3, 4'h4, 4'h6, 4'h0, 4'h5, 4'h7};
    localparam logic [9:0] WARN_LATCHABLE = 10'h3df;
    localparam logic [9:0] WARN_FOREVER   = 10'h084;

    // Number of synchronised pins and their positions
    localparam int unsigned NUM_PINS     = 6;
    localparam int unsigned PIN_FAN_STOP = 0;
    localparam int unsigned PIN_ENC_HOT  = 1;
    localparam int unsigned PIN_VIBRATE  = 2;
    localparam int unsigned PIN_EXT_WARN = 3;
    localparam int unsigned PIN_A_RESET  = 4;
    localparam int unsigned PIN_RUN      = 5;

    typedef struct packed {
        logic [7:0]  load_ratio;
        logic [7:0]  regen_ratio;
        logic [11:0] battery_mv;
        logic        enc_frame_ok;
        logic        enc_frame_err;
        logic        ext_frame_ok;
        logic        ext_frame_err;
        logic [15:0] cap_life;
        logic [15:0] fan_life;
    } wam_sense_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] code;
        logic       pcycle_only;
        logic       immediate;
    } wam_error_type;

endpackage

/* src/wam_hold.sv */
// Per-warning latch with hold time counted in whole seconds
`timescale 1ns/1ps
`default_nettype none

module wam_hold #(
    parameter int unsigned SEC_CYCLES = wam_pkg::SEC_CYCLES
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       cond_i,
    input  wire logic [3:0] hold_s_i,
    input  wire logic       forever_i,
    input  wire logic       clear_i,
    output logic            held_o
);

    localparam int unsigned CW = $clog2(SEC_CYCLES + 1);
    localparam logic [CW-1:0] SEC_LAST = CW'(SEC_CYCLES - 1);

    typedef struct packed {
        logic          held;
        logic [CW-1:0] cyc;
        logic [3:0]    secs;
    } wam_hold_state_type;

    wam_hold_state_type state_reg;
    wam_hold_state_type state_next;

    always_comb begin
        state_next = state_reg;
        if (cond_i) begin
            // A live condition restarts the hold and beats any clear
            state_next.held = 1'b1;
            state_next.cyc  = '0;
            state_next.secs = '0;
        end else if (state_reg.held) begin
            if (clear_i) begin
                state_next.held = 1'b0;
            end else if (!forever_i && state_reg.secs >= hold_s_i) begin
                state_next.held = 1'b0;
            end else if (state_reg.cyc == SEC_LAST) begin
                state_next.cyc  = '0;
                state_next.secs = (state_reg.secs == 4'hf) ? state_reg.secs : state_reg.secs + 4'h1;
            end else begin
                state_next.cyc = state_reg.cyc + CW'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign held_o = state_reg.held;

endmodule

`default_nettype wire

/* src/wam_top.sv */
// Warning and alarm manager for a servo drive protection path
`timescale 1ns/1ps
`default_nettype none

module wam_top #(
    parameter int unsigned SEC_CYCLES = wam_pkg::SEC_CYCLES
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // Register port
    input  wire logic [7:0]             addr_i,
    input  wire logic [31:0]            wdata_i,
    input  wire logic                   we_i,
    input  wire logic                   re_i,
    output logic [31:0]                 rdata_o,
    // Sensing from on-chip logic
    input  wire wam_pkg::wam_sense_type sense_i,
    input  wire wam_pkg::wam_error_type error_i,
    input  wire logic [31:0]            status_i,
    // Pins from outside
    input  wire logic                   fan_stopped_i,
    input  wire logic                   enc_overheat_i,
    input  wire logic                   vibration_i,
    input  wire logic                   ext_enc_warn_i,
    input  wire logic                   alarm_reset_i,
    input  wire logic                   run_i,
    // Outputs
    output logic                        warning_output_one_o,
    output logic                        warning_output_two_o,
    output logic                        alarm_output_o,
    output logic [7:0]                  alarm_code_o,
    output logic                        power_stage_enable_o,
    output logic                        immediate_stop_o
);

    localparam int unsigned NW = wam_pkg::NUM_WARN;
    localparam int unsigned NP = wam_pkg::NUM_PINS;
    localparam int unsigned CW = $clog2(SEC_CYCLES * wam_pkg::FAN_STOP_S + 1);
    localparam logic [CW-1:0] FAN_LAST = CW'(SEC_CYCLES * wam_pkg::FAN_STOP_S - 1);

    typedef struct packed {
        // Pin synchronisers and filtered levels
        logic [NP-1:0] sync1;
        logic [NP-1:0] sync2;
        logic [NP-1:0] sync3;
        logic [NP-1:0] pins;
        // Software settings
        logic [3:0]    hold;
        logic [10:0]   mask;
        logic [3:0]    sel_one;
        logic [3:0]    sel_two;
        logic [7:0]    enc_limit;
        logic [7:0]    ext_limit;
        logic [15:0]   life_thresh;
        // Detection state
        logic [CW-1:0] fan_cnt;
        logic          fan_warn;
        logic [7:0]    enc_errs;
        logic [7:0]    ext_errs;
        // Alarm state
        logic          alarm;
        logic          pcycle;
        logic          immediate;
        logic [7:0]    code;
        logic [31:0]   prev_status;
        logic [31:0]   snapshot;
        // Outputs
        logic          warn_one;
        logic          warn_two;
        logic [31:0]   rdata;
    } wam_state_type;

    wam_state_type state_reg;
    wam_state_type state_next;

    logic [NW-1:0] raw_cond;
    logic [NW-1:0] cond;
    logic [NW-1:0] held;
    logic [NW-1:0] active;
    logic [3:0]    hold_s;
    logic          sw_clear;
    logic          pin_clear;
    logic          clear;

    // Condition detection, one term per warning
    always_comb begin
        raw_cond    = '0;
        raw_cond[0] = sense_i.load_ratio >= wam_pkg::LOAD_WARN_PCT;
        raw_cond[1] = sense_i.regen_ratio >= wam_pkg::LOAD_WARN_PCT;
        raw_cond[2] = sense_i.battery_mv <= wam_pkg::BATT_WARN_MV;
        raw_cond[3] = state_reg.fan_warn;
        raw_cond[4] = state_reg.enc_errs > state_reg.enc_limit;
        raw_cond[5] = state_reg.pins[wam_pkg::PIN_ENC_HOT];
        raw_cond[6] = state_reg.pins[wam_pkg::PIN_VIBRATE];
        raw_cond[7] = (sense_i.cap_life < state_reg.life_thresh)
                    | (sense_i.fan_life < state_reg.life_thresh);
        raw_cond[8] = state_reg.pins[wam_pkg::PIN_EXT_WARN];
        raw_cond[9] = state_reg.ext_errs > state_reg.ext_limit;
    end

    // Hold time register above ten is treated as ten; zero means no limit
    assign hold_s = (state_reg.hold > wam_pkg::HOLD_MAX_S) ? wam_pkg::HOLD_MAX_S : state_reg.hold;

    // Clear requests from software and from the reset pin edge
    assign sw_clear  = we_i && (addr_i == wam_pkg::ADDR_CTRL) && wdata_i[wam_pkg::CTRL_CLEAR_BIT];
    // Taken from the synchroniser stages, not the next state, so the clear does not loop back into itself
    assign pin_clear = state_reg.sync2[wam_pkg::PIN_A_RESET] && state_reg.sync3[wam_pkg::PIN_A_RESET]
                     && !state_reg.pins[wam_pkg::PIN_A_RESET];
    assign clear     = sw_clear || pin_clear;

    generate
        for (genvar w = 0; w < NW; w++) begin : g_warn
            logic       w_forever;
            logic [3:0] w_hold;

            // A masked warning is not detected at all
            assign cond[w] = raw_cond[w] && !state_reg.mask[wam_pkg::WARN_MASK_BIT[w]];

            // Always-latched warnings ignore the hold setting
            assign w_forever = wam_pkg::WARN_FOREVER[w]
                             || (wam_pkg::WARN_LATCHABLE[w] && (hold_s == 4'h0));
            assign w_hold    = wam_pkg::WARN_LATCHABLE[w] ? hold_s : 4'h0;

            wam_hold #(
                .SEC_CYCLES (SEC_CYCLES)
            ) u_hold (
                .clk_i      (clk_i),
                .rst_i      (rst_i),
                .cond_i     (cond[w]),
                .hold_s_i   (w_hold),
                .forever_i  (w_forever),
                .clear_i    (clear),
                .held_o     (held[w])
            );

            assign active[w] = held[w] && !state_reg.mask[wam_pkg::WARN_MASK_BIT[w]];
        end
    endgenerate

    always_comb begin
        state_next = state_reg;

        // Three-stage synchroniser; a level counts once stages two and three agree
        state_next.sync1 = {run_i, alarm_reset_i, ext_enc_warn_i, vibration_i, enc_overheat_i, fan_stopped_i};
        state_next.sync2 = state_reg.sync1;
        state_next.sync3 = state_reg.sync2;
        for (int p = 0; p < NP; p++) begin
            if (state_reg.sync2[p] == state_reg.sync3[p]) begin
                state_next.pins[p] = state_reg.sync3[p];
            end
        end

        // Fan standstill timer
        if (!state_reg.pins[wam_pkg::PIN_FAN_STOP]) begin
            state_next.fan_cnt  = '0;
            state_next.fan_warn = 1'b0;
        end else if (state_reg.fan_cnt == FAN_LAST) begin
            state_next.fan_warn = 1'b1;
        end else begin
            state_next.fan_cnt = state_reg.fan_cnt + CW'(1);
        end

        // Consecutive frame error counters, saturating; a good frame restarts them
        if (sense_i.enc_frame_ok) begin
            state_next.enc_errs = 8'h00;
        end else if (sense_i.enc_frame_err && state_reg.enc_errs != 8'hff) begin
            state_next.enc_errs = state_reg.enc_errs + 8'h01;
        end
        if (sense_i.ext_frame_ok) begin
            state_next.ext_errs = 8'h00;
        end else if (sense_i.ext_frame_err && state_reg.ext_errs != 8'hff) begin
            state_next.ext_errs = state_reg.ext_errs + 8'h01;
        end

        // Warning outputs from latched, unmasked warnings of the selected type
        state_next.warn_one = 1'b0;
        state_next.warn_two = 1'b0;
        for (int w = 0; w < NW; w++) begin
            if (active[w] && (state_reg.sel_one == 4'h0 || state_reg.sel_one == 4'(w + 1))) begin
                state_next.warn_one = 1'b1;
            end
            if (active[w] && (state_reg.sel_two == 4'h0 || state_reg.sel_two == 4'(w + 1))) begin
                state_next.warn_two = 1'b1;
            end
        end

        // Snapshot source is always one cycle old, so it predates the error
        state_next.prev_status = status_i;

        // Alarm: a new error wins over a clear in the same cycle
        if (state_reg.alarm && clear && !state_reg.pcycle) begin
            state_next.alarm     = 1'b0;
            state_next.pcycle    = 1'b0;
            state_next.immediate = 1'b0;
        end
        if (error_i.valid && !(state_reg.alarm && !(clear && !state_reg.pcycle))) begin
            state_next.alarm     = 1'b1;
            state_next.code      = error_i.code;
            state_next.pcycle    = error_i.pcycle_only;
            state_next.immediate = error_i.immediate;
            state_next.snapshot  = state_reg.prev_status;
        end

        // Register writes
        if (we_i) begin
            unique case (addr_i)
                wam_pkg::ADDR_HOLD:        state_next.hold        = wdata_i[3:0];
                wam_pkg::ADDR_MASK:        state_next.mask        = wdata_i[10:0];
                wam_pkg::ADDR_SEL_ONE:     state_next.sel_one     = wdata_i[3:0];
                wam_pkg::ADDR_SEL_TWO:     state_next.sel_two     = wdata_i[3:0];
                wam_pkg::ADDR_ENC_LIMIT:   state_next.enc_limit   = wdata_i[7:0];
                wam_pkg::ADDR_EXT_LIMIT:   state_next.ext_limit   = wdata_i[7:0];
                wam_pkg::ADDR_LIFE_THRESH: state_next.life_thresh = wdata_i[15:0];
                default: ;
            endcase
        end

        // Read data stands only in the cycle after the read strobe
        state_next.rdata = 32'h0000_0000;
        if (re_i) begin
            unique case (addr_i)
                wam_pkg::ADDR_HOLD:        state_next.rdata = {28'h0, state_reg.hold};
                wam_pkg::ADDR_MASK:        state_next.rdata = {21'h0, state_reg.mask};
                wam_pkg::ADDR_SEL_ONE:     state_next.rdata = {28'h0, state_reg.sel_one};
                wam_pkg::ADDR_SEL_TWO:     state_next.rdata = {28'h0, state_reg.sel_two};
                wam_pkg::ADDR_ENC_LIMIT:   state_next.rdata = {24'h0, state_reg.enc_limit};
                wam_pkg::ADDR_EXT_LIMIT:   state_next.rdata = {24'h0, state_reg.ext_limit};
                wam_pkg::ADDR_LIFE_THRESH: state_next.rdata = {16'h0, state_reg.life_thresh};
                wam_pkg::ADDR_WARN_STAT:   state_next.rdata = {22'h0, active};
                wam_pkg::ADDR_ALARM_STAT: begin
                    state_next.rdata[wam_pkg::ASTAT_ACT_BIT]  = state_reg.alarm;
                    state_next.rdata[wam_pkg::ASTAT_PCYC_BIT] = state_reg.pcycle;
                    state_next.rdata[wam_pkg::ASTAT_IMM_BIT]  = state_reg.immediate;
                    state_next.rdata[wam_pkg::ASTAT_CODE_LSB +: 8] = state_reg.code;
                end
                wam_pkg::ADDR_SNAPSHOT:    state_next.rdata = state_reg.snapshot;
                default:                   state_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Reset stands for a power cycle and so clears every alarm kind
            state_reg             <= '0;
            state_reg.hold        <= wam_pkg::HOLD_RST;
            state_reg.mask        <= wam_pkg::MASK_RST;
            state_reg.sel_one     <= wam_pkg::SEL_RST;
            state_reg.sel_two     <= wam_pkg::SEL_RST;
            state_reg.enc_limit   <= wam_pkg::ENC_LIMIT_RST;
            state_reg.ext_limit   <= wam_pkg::ENC_LIMIT_RST;
            state_reg.life_thresh <= wam_pkg::LIFE_THRESH_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata_o              = state_reg.rdata;
    assign warning_output_one_o = state_reg.warn_one;
    assign warning_output_two_o = state_reg.warn_two;
    assign alarm_output_o       = state_reg.alarm;
    assign alarm_code_o         = state_reg.alarm ? state_reg.code : 8'h00;
    assign immediate_stop_o     = state_reg.alarm && state_reg.immediate;
    // No latch on run: the stage comes back the cycle the alarm falls, so the host must drop run first
    assign power_stage_enable_o = state_reg.pins[wam_pkg::PIN_RUN] && !state_reg.alarm;

endmodule

`default_nettype wire

/* verification/wam_top_asserts.sv */
// Port checker for the warning and alarm manager
`timescale 1ns/1ps
`default_nettype none
module wam_top_asserts (
    input wire logic                   clk_i,
    input wire logic                   rst_i,
    input wire logic [7:0]             addr_i,
    input wire logic [31:0]            wdata_i,
    input wire logic                   we_i,
    input wire wam_pkg::wam_error_type error_i,
    input wire logic                   alarm_reset_i,
    input wire logic                   run_i,
    input wire logic                   alarm_output_o,
    input wire logic [7:0]             alarm_code_o,
    input wire logic                   power_stage_enable_o,
    input wire logic                   immediate_stop_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic clr;
    logic pc_reg;
    assign clr = we_i && addr_i == wam_pkg::ADDR_CTRL && wdata_i[0];
    // Attribute of the alarm in force, since it is not visible at the ports
    always_ff @(posedge clk_i)
        if (rst_i) pc_reg <= 1'b0;
        else if (error_i.valid && (!alarm_output_o || (clr && !pc_reg))) pc_reg <= error_i.pcycle_only;
    sequence s_pin_quiet;
        (!alarm_reset_i) [*6];
    endsequence
    sequence s_run_held;
        run_i [*6];
    endsequence
    AST_ALARM_SET: assert property (error_i.valid && !alarm_output_o |=>
        alarm_output_o && alarm_code_o == $past(error_i.code)) else $error("alarm not raised with its code");
    AST_POWER_OFF: assert property (alarm_output_o |-> !power_stage_enable_o)
        else $error("power stage on during alarm");
    AST_CODE_ZERO: assert property (!alarm_output_o |-> alarm_code_o == 8'h00 && !immediate_stop_o)
        else $error("code or stop shown without alarm");
    AST_IMM_STOP: assert property ($rose(alarm_output_o) |-> immediate_stop_o == $past(error_i.immediate))
        else $error("stop attribute wrong");
    AST_SW_CLEAR: assert property (alarm_output_o && clr && !pc_reg && !error_i.valid |=> !alarm_output_o)
        else $error("software clear ignored");
    AST_PCYC_KEEP: assert property (alarm_output_o && clr && pc_reg |=> alarm_output_o)
        else $error("power cycle alarm cleared by command");
    AST_RESUME: assert property (s_run_held ##0 (alarm_output_o && clr && !pc_reg && !error_i.valid) |=>
        power_stage_enable_o) else $error("stage not resumed on clear");
    AST_ALARM_STAYS: assert property (s_pin_quiet ##0 (alarm_output_o && !clr) |=> alarm_output_o)
        else $error("alarm dropped without a clear");
endmodule
bind wam_top wam_top_asserts u_chk (.clk_i, .rst_i, .addr_i, .wdata_i, .we_i, .error_i, .alarm_reset_i,
    .run_i, .alarm_output_o, .alarm_code_o, .power_stage_enable_o, .immediate_stop_o);
`default_nettype wire

/* verification/wam_host.sv */
// Host controller model driving the run and alarm reset pins
`timescale 1ns/1ps
`default_nettype none
module wam_host (
    input  wire logic clk_i,
    output logic      run_o,
    output logic      alarm_reset_o
);
    initial begin
        run_o = 1'b1;
        alarm_reset_o = 1'b0;
    end
    // A careless host keeps run up, so the stage restarts the moment the alarm goes
    task automatic clear_alarm(input logic careful);
        @(posedge clk_i);
        run_o <= run_o && !careful;
        repeat (6) @(posedge clk_i);
        alarm_reset_o <= 1'b1;
        repeat (6) @(posedge clk_i);
        alarm_reset_o <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

/* verification/wam_top_tb.sv */
// Self-checking bench for the warning and alarm manager
`timescale 1ns/1ps
`default_nettype none
module wam_top_tb;
    localparam int unsigned SEC = 20;
    localparam logic [3:0] MBIT [10] = '{4'h7, 4'h5, 4'h0, 4'h6, 4'h4, 4'h3, 4'h9, 4'h2, 4'h8, 4'ha};
    logic                   clk_i, rst_i, we_i, re_i, fan_stopped_i, enc_overheat_i, vibration_i;
    logic                   ext_enc_warn_i, alarm_reset_i, run_i, alarm_output_o, immediate_stop_o;
    logic                   warning_output_one_o, warning_output_two_o, power_stage_enable_o;
    logic [7:0]             addr_i, alarm_code_o;
    logic [31:0]            wdata_i, rdata_o, status_i, rd_v;
    logic [31:0]            rng = 32'h6d5a;
    wam_pkg::wam_sense_type sense_i;
    wam_pkg::wam_error_type error_i;
    int                     errors = 0, checked = 0, cyc = 0;
    wam_top #(.SEC_CYCLES(SEC)) DUT (.clk_i, .rst_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .sense_i,
        .error_i, .status_i, .fan_stopped_i, .enc_overheat_i, .vibration_i, .ext_enc_warn_i, .alarm_reset_i,
        .run_i, .warning_output_one_o, .warning_output_two_o, .alarm_output_o, .alarm_code_o,
        .power_stage_enable_o, .immediate_stop_o);
    wam_host host (.clk_i, .run_o(run_i), .alarm_reset_o(alarm_reset_i));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    task automatic print_verdict();
        $display("Checks %0d, errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic waitc(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    // One access; read data are taken in the cycle after the strobe
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {we_i, re_i, addr_i, wdata_i} <= {w, !w, a, d};
        @(posedge clk_i);
        {we_i, re_i} <= 2'b00;
        #1 rd_v = rdata_o;
    endtask
    // Boundary values: the off level sits one step on the safe side
    task automatic cond(input int n, input logic on);
        @(posedge clk_i);
        case (n)
            0: sense_i.load_ratio <= on ? 8'h55 : 8'h54;
            1: sense_i.regen_ratio <= on ? 8'h55 : 8'h54;
            2: sense_i.battery_mv <= on ? 12'hc80 : 12'hc81;
            3: fan_stopped_i <= on;
            5: enc_overheat_i <= on;
            6: vibration_i <= on;
            7: sense_i.fan_life <= on ? 16'h0063 : 16'h0064;
            8: ext_enc_warn_i <= on;
            default: repeat (on ? 4 : 1) begin
                {sense_i.enc_frame_err, sense_i.ext_frame_err} <= (n == 4) ? {on, 1'b0} : {1'b0, on};
                {sense_i.enc_frame_ok, sense_i.ext_frame_ok} <= (n == 4) ? {!on, 1'b0} : {1'b0, !on};
                @(posedge clk_i);
                {sense_i.enc_frame_err, sense_i.ext_frame_err, sense_i.enc_frame_ok, sense_i.ext_frame_ok} <= 4'h0;
                @(posedge clk_i);
            end
        endcase
    endtask
    task automatic hit(input logic pc);
        logic [31:0] snap;
        rng = xs(rng);
        snap = rng;
        @(posedge clk_i);
        status_i <= snap;
        @(posedge clk_i);
        error_i <= {1'b1, snap[15:8], pc, snap[16]};
        status_i <= ~snap;
        @(posedge clk_i);
        error_i.valid <= 1'b0;
        #1 chk(32'({alarm_output_o, power_stage_enable_o, immediate_stop_o, alarm_code_o}),
            32'({2'b10, snap[16], snap[15:8]}));
        bus(1'b0, wam_pkg::ADDR_ALARM_STAT, 32'h0);
        chk(rd_v, 32'({snap[15:8], 5'h0, snap[16], pc, 1'b1}));
        bus(1'b0, wam_pkg::ADDR_SNAPSHOT, 32'h0);
        chk(rd_v, snap);
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        rst_i = 1'b1;
        {we_i, re_i, addr_i, wdata_i, status_i, error_i} = '0;
        {fan_stopped_i, enc_overheat_i, vibration_i, ext_enc_warn_i} = 4'h0;
        sense_i = '0;
        sense_i.battery_mv = 12'hfff;
        {sense_i.cap_life, sense_i.fan_life} = 32'hffff_ffff;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, wam_pkg::ADDR_HOLD, 32'h0);
        chk(rd_v, 32'h1);
        bus(1'b0, 8'h2c, 32'h0);
        chk(rd_v, 32'h0);
        for (int n = 0; n < 10; n++) begin
            bus(1'b1, wam_pkg::ADDR_SEL_ONE, 32'(n + 1));
            bus(1'b1, wam_pkg::ADDR_SEL_TWO, (n % 2) ? 32'h0 : 32'((n + 1) % 10 + 1));
            bus(1'b1, wam_pkg::ADDR_MASK, 32'h7ff ^ (32'h1 << MBIT[n]));
            cond(n, 1'b1);
            waitc(SEC + 20);
            bus(1'b0, wam_pkg::ADDR_WARN_STAT, 32'h0);
            chk(rd_v, 32'h1 << n);
            chk(32'({warning_output_one_o, warning_output_two_o}), 32'({1'b1, n[0]}));
            cond(n, 1'b0);
            waitc(10);
            chk(32'(warning_output_one_o), 32'(n != 5));
            if (n % 2 == 0) bus(1'b1, wam_pkg::ADDR_CTRL, 32'h1);
            else waitc(SEC + 20);
            waitc(3);
            chk(32'(warning_output_one_o), 32'(n == 7));
            bus(1'b1, wam_pkg::ADDR_CTRL, 32'h1);
            bus(1'b1, wam_pkg::ADDR_MASK, 32'h1 << MBIT[n]);
            cond(n, 1'b1);
            waitc(SEC + 20);
            bus(1'b0, wam_pkg::ADDR_WARN_STAT, 32'h0);
            chk(rd_v | 32'(warning_output_one_o), 32'h0);
            cond(n, 1'b0);
            waitc(8);
        end
        hit(1'b0);
        bus(1'b1, wam_pkg::ADDR_CTRL, 32'h1);
        chk(32'({alarm_output_o, power_stage_enable_o}), 32'h1);
        hit(1'b0);
        host.clear_alarm(1'b1);
        chk(32'({alarm_output_o, power_stage_enable_o}), 32'h0);
        hit(1'b1);
        bus(1'b1, wam_pkg::ADDR_CTRL, 32'h1);
        host.clear_alarm(1'b0);
        chk(32'(alarm_output_o), 32'h1);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        waitc(2);
        chk(32'(alarm_output_o), 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
